//--- rtl/dtc_defs.vh
`ifndef DTC_DEFS_VH
`define DTC_DEFS_VH
// Register byte offsets
`define DTC_OFF_MODE      8'h00
`define DTC_OFF_LAT       8'h04
`define DTC_OFF_STATUS    8'h08
`define DTC_OFF_TIMING    8'h0C
// Mode register field positions
`define DTC_MODE_FREEZE   0
`define DTC_MODE_WTERM_LO 1
`define DTC_MODE_WTERM_HI 2
// Latency register field positions
`define DTC_LAT_CWL_LSB   0
`define DTC_LAT_AL_LSB    8
// Timing register field positions
`define DTC_TIM_CPDED_LSB 0
`define DTC_TIM_RFC_LSB   8
`define DTC_TIM_XPDLL_LSB 16
// Reset values
`define DTC_RST_MODE      32'h0000_0000
`define DTC_RST_LAT       32'h0000_0005
`define DTC_RST_TIMING    32'h0018_3404
// Asynchronous termination delays in picoseconds
`define DTC_ASYNC_MIN_PS  2000
`define DTC_ASYNC_MAX_PS  8500
`define DTC_CLK_PS        40000
// Write-to-nominal extra cycles
`define DTC_CHOP_EXTRA    4
`define DTC_FULL_EXTRA    6
`endif

//--- rtl/dtc_delay_line.v
`timescale 1ns/1ns
// Programmable delay line: output is the input delayed by sel cycles (0 = pass through)
module dtc_delay_line #(
	parameter DEPTH = 32,
	parameter SW    = 5
) (
	input  wire          hclk,
	input  wire          hresetn,
	input  wire          din,
	input  wire [SW-1:0] sel,
	output wire          dout
);
	reg [DEPTH-1:0] shift_q;

	// Shift register tap
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			shift_q <= {DEPTH{1'b0}};
		end else begin
			shift_q <= {shift_q[DEPTH-2:0], din};
		end
	end

	assign dout = (sel == {SW{1'b0}}) ? din : shift_q[sel - 1'b1];
endmodule

//--- rtl/dtc_top.v
// Functional notes
// - Async termination only when loop frozen in powerdown
// - Async path skips additive latency
// - Async turn-on between 2 and 8.5 ns; here one 40 ns clock cycle after the synchroniser
// - Async turn-off between 2 and 8.5 ns; here one 40 ns clock cycle after the synchroniser
// - Request receiver alive in powerdown; no commands
// - Freeze bit zero: transition window at entry
// - Entry window: WL-1 before, powerdown delay after
// - Start cycle excluded, end points included
// - Refresh in progress extends entry window end
// - Turn-on in window within combined bounds
// - Turn-off in window within combined bounds
// - Exit window: WL-1 before, locked-exit time after
// - Entry/exit overlap: uncertain until exit end
// - Exit/entry overlap: uncertain until entry end
// - Sync latency is write latency minus two
// - Dynamic termination when either select bit set
// - Write strength after latency, nominal after plus four/six
//
// Design decisions made here: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/1ns
`include "dtc_defs.vh"
module dtc_top #(
	parameter DEPTH = 32,
	parameter SW    = 5
) (
	input  wire        hclk,
	input  wire        hresetn,
	input  wire        hsel,
	input  wire [31:0] haddr,
	input  wire [1:0]  htrans,
	input  wire        hwrite,
	input  wire [2:0]  hsize,
	input  wire [31:0] hwdata,
	input  wire        hready,
	output reg  [31:0] hrdata,
	output reg         hreadyout,
	output reg         hresp,
	input  wire        termination_request,
	input  wire        clock_enable_pin,
	input  wire        write_cmd,
	input  wire        write_chop,
	input  wire        refresh_cmd,
	output reg         term_enable,
	output reg         term_write_strength,
	output reg         term_uncertain,
	output reg         term_async_mode
);
	// Asynchronous delay in cycles: least rounds up, longest rounds down, at least one
	localparam ASYNC_MIN_CYC = (`DTC_ASYNC_MIN_PS + `DTC_CLK_PS - 1) / `DTC_CLK_PS;
	localparam ASYNC_MAX_RAW = `DTC_ASYNC_MAX_PS / `DTC_CLK_PS;
	localparam ASYNC_MAX_CYC = (ASYNC_MAX_RAW < 1) ? 1 : ASYNC_MAX_RAW;
	localparam ASYNC_CYC     = (ASYNC_MIN_CYC > ASYNC_MAX_CYC) ? ASYNC_MIN_CYC : ASYNC_MAX_CYC;
	// Longest delay the tap line can give; larger latencies saturate here instead of wrapping to zero
	localparam integer MAX_LAT = DEPTH - 1;

	// Power state one-hot codes
	localparam [2:0] ST_IDLE = 3'b001;
	localparam [2:0] ST_PD   = 3'b010;
	localparam [2:0] ST_EXIT = 3'b100;

	// Saturating subtract for latency arithmetic
	function [SW-1:0] lat_minus;
		input [7:0] a;
		input [7:0] b;
		begin
			if (a > b)
				lat_minus = (a - b > MAX_LAT) ? MAX_LAT[SW-1:0] : a[SW-1:0] - b[SW-1:0];
			else
				lat_minus = {SW{1'b0}};
		end
	endfunction

	reg [31:0] mode_q;
	reg [31:0] lat_q;
	reg [31:0] timing_q;
	reg        ph_valid_q;
	reg        ph_write_q;
	reg [7:0]  ph_addr_q;
	// Two-stage synchronisers for pins
	reg        req_s1_q, req_s2_q;
	reg        cke_s1_q, cke_s2_q;
	reg        wr_s1_q, wr_s2_q;
	reg        chop_s1_q, chop_s2_q;
	reg        ref_s1_q, ref_s2_q;
	reg        cke_prev_q;
	reg [2:0]  state_q, state_d;
	reg [SW-1:0] async_cnt_q;
	reg        async_term_q;
	reg [7:0]  nominal_cnt_q;
	wire       ref_busy;
	reg [7:0]  ref_cnt_q;
	reg [SW+1:0] pre_cnt_q;

	wire        freeze_sel  = ~mode_q[`DTC_MODE_FREEZE];
	wire        dyn_enable  = mode_q[`DTC_MODE_WTERM_LO] | mode_q[`DTC_MODE_WTERM_HI];
	wire [7:0]  write_cas_latency         = lat_q[`DTC_LAT_CWL_LSB +: 8];
	wire [7:0]  al          = lat_q[`DTC_LAT_AL_LSB +: 8];
	wire [7:0]  wl          = write_cas_latency + al;
	wire [SW-1:0] sync_lat  = lat_minus(wl, 8'h02);
	wire [7:0]  anpd        = (wl > 8'h01) ? wl - 8'h01 : 8'h00;
	wire        cke_fall    = cke_prev_q & ~cke_s2_q;
	wire        cke_rise    = ~cke_prev_q & cke_s2_q;
	wire        sync_req;
	wire        wr_on;
	wire        wr_off;
	wire        entry_win;
	wire        exit_win;
	wire [7:0]  entry_len;

	// AHB-Lite address phase capture
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ph_valid_q <= 1'b0;
			ph_write_q <= 1'b0;
			ph_addr_q  <= 8'h00;
		end else if (hready) begin
			ph_valid_q <= hsel & htrans[1];
			ph_write_q <= hwrite;
			ph_addr_q  <= haddr[7:0];
		end
	end

	// Register writes in data phase
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mode_q   <= `DTC_RST_MODE;
			lat_q    <= `DTC_RST_LAT;
			timing_q <= `DTC_RST_TIMING;
		end else if (ph_valid_q && ph_write_q) begin
			case (ph_addr_q)
				`DTC_OFF_MODE:   mode_q   <= {29'h0, hwdata[2:0]};
				`DTC_OFF_LAT:    lat_q    <= {16'h0, hwdata[15:0]};
				`DTC_OFF_TIMING: timing_q <= {8'h0, hwdata[23:0]};
				default:         mode_q   <= mode_q;
			endcase
		end
	end

	// Read data registered, zero-wait answer, always OKAY
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata    <= 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			if (hready && hsel && htrans[1] && !hwrite) begin
				case (haddr[7:0])
					`DTC_OFF_MODE:   hrdata <= mode_q;
					`DTC_OFF_LAT:    hrdata <= lat_q;
					`DTC_OFF_TIMING: hrdata <= timing_q;
					`DTC_OFF_STATUS: hrdata <= {25'h0, state_q, term_async_mode, term_uncertain,
								     term_write_strength, term_enable};
					default:         hrdata <= 32'h0000_0000;
				endcase
			end
		end
	end

	// Pin synchronisers; request receiver stays live in powerdown
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			req_s1_q  <= 1'b0;
			req_s2_q  <= 1'b0;
			cke_s1_q  <= 1'b1;
			cke_s2_q  <= 1'b1;
			cke_prev_q <= 1'b1;
			wr_s1_q   <= 1'b0;
			wr_s2_q   <= 1'b0;
			chop_s1_q <= 1'b0;
			chop_s2_q <= 1'b0;
			ref_s1_q  <= 1'b0;
			ref_s2_q  <= 1'b0;
		end else begin
			req_s1_q  <= termination_request;
			req_s2_q  <= req_s1_q;
			cke_s1_q  <= clock_enable_pin;
			cke_s2_q  <= cke_s1_q;
			cke_prev_q <= cke_s2_q;
			wr_s1_q   <= write_cmd;
			wr_s2_q   <= wr_s1_q;
			chop_s1_q <= write_chop;
			chop_s2_q <= chop_s1_q;
			ref_s1_q  <= refresh_cmd;
			ref_s2_q  <= ref_s1_q;
		end
	end

	// Power-down state machine
	always @* begin
		case (state_q)
			ST_IDLE: state_d = cke_fall ? ST_PD : ST_IDLE;
			ST_PD:   state_d = cke_rise ? ST_EXIT : ST_PD;
			ST_EXIT: state_d = cke_fall ? ST_PD : (exit_win ? ST_EXIT : ST_IDLE);
			default: state_d = ST_IDLE;
		endcase
	end

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			state_q <= ST_IDLE;
		else
			state_q <= state_d;
	end

	// Synchronous path: registered request delayed by write latency minus two, additive latency included
	dtc_delay_line #(.DEPTH(DEPTH), .SW(SW)) u_req_dly (
		.hclk    (hclk),
		.hresetn (hresetn),
		.din     (req_s2_q),
		.sel     (sync_lat),
		.dout    (sync_req)
	);

	// Write command delayed by the same latency selects write strength
	dtc_delay_line #(.DEPTH(DEPTH), .SW(SW)) u_wr_dly (
		.hclk    (hclk),
		.hresetn (hresetn),
		.din     (wr_s2_q & dyn_enable),
		.sel     (sync_lat),
		.dout    (wr_on)
	);
	assign wr_off = (nominal_cnt_q == 8'h01);

	// Count from write command to nominal return: latency plus four or six cycles
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			nominal_cnt_q <= 8'h00;
		end else if (wr_s2_q && dyn_enable) begin
			nominal_cnt_q <= {3'b000, sync_lat} + (chop_s2_q ? 8'd`DTC_CHOP_EXTRA : 8'd`DTC_FULL_EXTRA);
		end else if (nominal_cnt_q != 8'h00) begin
			nominal_cnt_q <= nominal_cnt_q - 8'h01;
		end
	end

	// Refresh busy tracking for window extension
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ref_cnt_q <= 8'h00;
		end else if (ref_s2_q) begin
			ref_cnt_q <= timing_q[`DTC_TIM_RFC_LSB +: 8];
		end else if (ref_cnt_q != 8'h00) begin
			ref_cnt_q <= ref_cnt_q - 8'h01;
		end
	end
	assign ref_busy = (ref_cnt_q != 8'h00);

	// Entry window end: later of powerdown delay and remaining refresh time, endpoints included
	assign entry_len = (ref_busy && ref_cnt_q > timing_q[`DTC_TIM_CPDED_LSB +: 8]) ?
			   ref_cnt_q : timing_q[`DTC_TIM_CPDED_LSB +: 8];

	dtc_window_timer #(.W(8)) u_entry_win (
		.hclk    (hclk),
		.hresetn (hresetn),
		.load    (cke_fall & freeze_sel),
		.value   (entry_len + 8'h01),
		.active  (entry_win)
	);

	dtc_window_timer #(.W(8)) u_exit_win (
		.hclk    (hclk),
		.hresetn (hresetn),
		.load    (cke_rise & freeze_sel),
		.value   (timing_q[`DTC_TIM_XPDLL_LSB +: 8]),
		.active  (exit_win)
	);

	// Lead-in: uncertainty covers write latency minus one cycles before clock-enable edge;
	// since that edge is not known in advance, the status marks the lead-in after the fact
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			pre_cnt_q <= {(SW+2){1'b0}};
		else if ((cke_fall | cke_rise) && freeze_sel)
			pre_cnt_q <= anpd[SW+1:0];
		else if (pre_cnt_q != {(SW+2){1'b0}})
			pre_cnt_q <= pre_cnt_q - 1'b1;
	end

	// Asynchronous path: direct from sampled request, no additive latency, fixed ns delay
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			async_cnt_q  <= {SW{1'b0}};
			async_term_q <= 1'b0;
		end else if (req_s2_q != async_term_q) begin
			if (async_cnt_q >= ASYNC_CYC[SW-1:0] - 1'b1) begin
				async_cnt_q  <= {SW{1'b0}};
				async_term_q <= req_s2_q;
			end else begin
				async_cnt_q <= async_cnt_q + 1'b1;
			end
		end else begin
			async_cnt_q <= {SW{1'b0}};
		end
	end

	// Output selection: async in frozen powerdown, sync outside windows; in a window both paths must agree to change it; windows flag uncertainty
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			term_enable         <= 1'b0;
			term_write_strength <= 1'b0;
			term_uncertain      <= 1'b0;
			term_async_mode     <= 1'b0;
		end else begin
			term_async_mode <= freeze_sel && (state_q == ST_PD);
			if (freeze_sel && state_q == ST_PD && !entry_win)
				term_enable <= async_term_q;
			else if (freeze_sel && (entry_win || exit_win))
				term_enable <= sync_req | async_term_q ? (sync_req & async_term_q) | term_enable & (sync_req | async_term_q) : 1'b0;
			else
				term_enable <= sync_req;
			if (wr_on)
				term_write_strength <= 1'b1;
			else if (wr_off || !dyn_enable)
				term_write_strength <= 1'b0;
			// Overlapping windows merge into one continuous uncertain span
			term_uncertain <= freeze_sel && (entry_win || exit_win || pre_cnt_q != {(SW+2){1'b0}});
		end
	end
endmodule

//--- rtl/dtc_window_timer.v
`timescale 1ns/1ns
// Down counter holding a window open: load starts, done when count runs out
module dtc_window_timer #(
	parameter W = 8
) (
	input  wire         hclk,
	input  wire         hresetn,
	input  wire         load,
	input  wire [W-1:0] value,
	output wire         active
);
	reg [W-1:0] cnt_q;

	// Reload on start, count down to zero otherwise
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_q <= {W{1'b0}};
		end else if (load) begin
			cnt_q <= value;
		end else if (cnt_q != {W{1'b0}}) begin
			cnt_q <= cnt_q - 1'b1;
		end
	end

	assign active = (cnt_q != {W{1'b0}});
endmodule

//--- verification/dtc_chk_sva.sv
`timescale 1ns/1ns
module dtc_chk (
	input logic hclk,
	input logic hresetn,
	input logic hreadyout,
	input logic hresp,
	input logic termination_request,
	input logic clock_enable_pin,
	input logic term_enable,
	input logic term_write_strength,
	input logic term_uncertain,
	input logic term_async_mode
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	logic [7:0] unc_q;
	// Length of the current uncertain stretch, saturating
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			unc_q <= 8'h00;
		else
			unc_q <= term_uncertain ? unc_q + {7'h00, unc_q != 8'hFF} : 8'h00;
	end
	property p_bus;
		hresp == 1'b0 && hreadyout == 1'b1;
	endproperty
	a_bus: assert property (p_bus) else $error("bus answer not ready or not okay");
	property p_awake;
		clock_enable_pin [*5] |-> !term_async_mode;
	endproperty
	a_awake: assert property (p_awake) else $error("async mode while awake");
	property p_pdin;
		$rose(term_async_mode) |-> !$past(clock_enable_pin);
	endproperty
	a_pdin: assert property (p_pdin) else $error("async mode without powerdown");
	property p_aon;
		term_async_mode && !term_uncertain && $rose(termination_request) |-> ##[1:6] term_enable;
	endproperty
	a_aon: assert property (p_aon) else $error("async turn-on late");
	property p_aof;
		term_async_mode && !term_uncertain && $fell(termination_request) |-> ##[1:6] !term_enable;
	endproperty
	a_aof: assert property (p_aof) else $error("async turn-off late");
	property p_son;
		!term_async_mode && !term_uncertain && clock_enable_pin && $rose(termination_request)
			|-> ##[2:10] term_enable;
	endproperty
	a_son: assert property (p_son) else $error("sync turn-on out of range");
	property p_ws;
		$rose(term_write_strength) |-> term_write_strength [*4] ##[1:3] !term_write_strength;
	endproperty
	a_ws: assert property (p_ws) else $error("write strength width wrong");
	property p_unc;
		unc_q < 8'd200;
	endproperty
	a_unc: assert property (p_unc) else $error("uncertain window never ends");
endmodule
bind dtc_top dtc_chk u_chk (.hclk, .hresetn, .hreadyout, .hresp, .termination_request, .clock_enable_pin,
	.term_enable, .term_write_strength, .term_uncertain, .term_async_mode);

//--- verification/dtc_ctl_model.sv
`timescale 1ns/1ns
module dtc_ctl_model (
	input  logic hclk,
	output logic termination_request,
	output logic clock_enable_pin,
	output logic write_cmd,
	output logic write_chop,
	output logic refresh_cmd
);
	// Pins idle, device awake
	initial begin
		termination_request = 1'b0;
		clock_enable_pin = 1'b1;
		write_cmd = 1'b0;
		write_chop = 1'b0;
		refresh_cmd = 1'b0;
	end
	// Request pulse, optionally with a write; held long enough for the burst
	task burst(input int hold, input logic w, input logic c);
		int k;
		k = w ? (c ? 4 : 6) : 4;
		if (hold > k)
			k = hold;
		@(posedge hclk);
		termination_request <= 1'b1;
		write_cmd <= w & clock_enable_pin;
		write_chop <= c;
		@(posedge hclk);
		write_cmd <= 1'b0;
		repeat (k - 1) @(posedge hclk);
		termination_request <= 1'b0;
	endtask
	// Refresh pulse
	task refresh;
		@(posedge hclk);
		refresh_cmd <= 1'b1;
		@(posedge hclk);
		refresh_cmd <= 1'b0;
	endtask
	// Powerdown entry (0) or exit (1); window state is treated as unknown, no requests sent in it
	task pd(input logic v);
		@(posedge hclk);
		clock_enable_pin <= v;
	endtask
endmodule

//--- verification/tb.sv
`timescale 1ns/1ns
module tb;
	logic        hclk, hresetn, hsel, hwrite, s;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic        hreadyout, hresp, termination_request, clock_enable_pin, write_cmd, write_chop, refresh_cmd;
	logic        term_enable, term_write_strength, term_uncertain, term_async_mode;
	logic [3:0]  o;
	int          err_total, checks_done, n, ns;
	assign o = {term_async_mode, term_uncertain, term_write_strength, term_enable};
	dtc_top dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata,
		.hreadyout, .hresp, .termination_request, .clock_enable_pin, .write_cmd, .write_chop, .refresh_cmd,
		.term_enable, .term_write_strength, .term_uncertain, .term_async_mode);
	dtc_ctl_model m (.hclk, .termination_request, .clock_enable_pin, .write_cmd, .write_chop, .refresh_cmd);
	// Clock
	initial begin
		hclk = 1'b0;
		forever #20 hclk = ~hclk;
	end
	task end_sim;
		if (err_total == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task tmo;
		err_total++;
		$display("mismatch %0t wait ran out", $time);
		end_sim;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e, input string t);
		checks_done++;
		if (g !== e) begin
			$display("mismatch %0t %s", $time, t);
			err_total++;
		end
	endtask
	// Wait for one output to reach a level, counting edges
	task wt(input int k, input logic v, input int lim);
		n = 0;
		while (o[k] !== v) begin
			@(posedge hclk);
			n++;
			if (n > lim)
				tmo;
		end
	endtask
	task rdy;
		int k;
		k = 0;
		do begin
			@(posedge hclk);
			k++;
		end while (hreadyout !== 1'b1 && k < 20);
		if (hreadyout !== 1'b1)
			tmo;
	endtask
	// One single word transfer
	task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		htrans <= 2'h2;
		rdy;
		htrans <= 2'h0;
		hwdata <= d;
		rdy;
		rd = hrdata;
	endtask
	task regs;
		bus(0, 32'h00, 0);
		chk(rd, 32'h0000_0000, "mode reset");
		bus(0, 32'h0C, 0);
		chk(rd, 32'h0018_3404, "timing reset");
		bus(1, 32'h04, 32'h0000_0007);
		bus(0, 32'h04, 0);
		chk(rd, 32'h0000_0007, "latency write");
		bus(1, 32'h04, 32'h0000_0005);
		bus(1, 32'h10, 32'hFFFF_FFFF);
		bus(0, 32'h10, 0);
		chk(rd, 32'h0000_0000, "unmapped read");
	endtask
	task sync_on;
		bus(1, 32'h00, 32'h0000_0001);
		fork
			m.burst(6, 0, 0);
			wt(0, 1, 20);
		join
		ns = n;
		chk(n >= 5 && n <= 8, 1, "sync turn-on");
		wt(0, 0, 20);
	endtask
	task dyn;
		for (int i = 0; i < 8; i++) begin
			bus(1, 32'h00, 32'(i | 1));
			s = 1'b0;
			n = 0;
			fork
				m.burst(6, 1, i[0]);
				repeat (16) begin
					@(posedge hclk);
					s = s | term_write_strength;
					n = term_write_strength ? n + 1 : n;
				end
			join
			chk(i < 2 ? {31'h0, s} : n, i < 2 ? 0 : (i[0] ? 4 : 6), "write strength");
			wt(0, 0, 30);
		end
	endtask
	task async_pd(input logic r);
		bus(1, 32'h00, 32'h0000_0000);
		if (r)
			m.refresh;
		m.pd(0);
		wt(2, 1, 20);
		wt(2, 0, 200);
		chk(r ? n >= 40 : n <= 20, 1, "entry window length");
		chk(term_async_mode, 1, "async mode");
		// Status word: of the four output flags only the async flag may be up once the entry window has closed
		bus(0, 32'h08, 0);
		chk(rd[3:0], 4'h8, "status in frozen powerdown");
		fork
			m.burst(6, 0, 0);
			wt(0, 1, 10);
		join
		chk(n < ns, 1, "async skips latency");
		wt(0, 0, 10);
		m.pd(1);
		wt(3, 0, 20);
		wt(2, 1, 20);
		wt(2, 0, 100);
	endtask
	task no_freeze;
		bus(1, 32'h00, 32'h0000_0001);
		m.pd(0);
		s = 1'b0;
		repeat (20) begin
			@(posedge hclk);
			s = s | term_uncertain | term_async_mode;
		end
		chk(s, 0, "loop running");
		m.pd(1);
		repeat (8) @(posedge hclk);
	endtask
	// Short powerdown, then short idle: the overlapping windows must form one unbroken span
	task short_pd;
		bus(1, 32'h00, 32'h0000_0000);
		m.pd(0);
		repeat (3) @(posedge hclk);
		m.pd(1);
		wt(2, 1, 20);
		wt(2, 0, 100);
		chk(n >= 20, 1, "entry/exit span broken");
		m.pd(0);
		wt(2, 1, 20);
		wt(2, 0, 100);
		m.pd(1);
		m.pd(0);
		wt(2, 1, 20);
		wt(2, 0, 100);
		chk(n >= 20, 1, "exit/entry span broken");
		m.pd(1);
		wt(2, 1, 20);
		wt(2, 0, 100);
	endtask
	// Main sequence
	initial begin
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		err_total = 0;
		checks_done = 0;
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		regs;
		sync_on;
		dyn;
		async_pd(0);
		async_pd(1);
		short_pd;
		no_freeze;
		end_sim;
	end
endmodule
